// ### common/ctm_pkg.sv
// Package: register map, field layouts, modes and clock codes of the compact timer
// ------------------------------------------------------------
// Summary of operation
// - Pause bit high holds the counter; clearing it resumes from the held value.
// - Clock field picks sys/4, sys, high/16, high/64, sub, pin rise, pin fall.
// - Counter-on rising edge clears the counter to zero before counting.
// - Counter-on low stops counting and keeps the residual count.
// - Counter-on rising edge restores the initial output level in compare and PWM.
// - Mode field: 00 compare output, 10 PWM, 11 timer/counter, 01 undefined.
// - Timer/counter mode ignores output function, initial level and polarity bits.
// - Compare mode A match: 00 hold, 01 low, 10 high, 11 toggle the output.
// - PWM output function: 00 inactive, 01 active, 10 waveform, 11 undefined.
// - Compare mode initial level bit sets pin before any match; same level, no change.
// - PWM mode initial level bit selects active low (0) or active high (1).
// - Polarity bit one inverts the output pin; zero passes it straight.
// - Swap bit 0: P sets period, A duty; 1: roles reversed.
// - Clear-source 1 clears on A match; 0 clears on P match or overflow.
// - Overflow raises the P request under clear-source 0 only when P value is all zero.
// - PWM mode ignores clear-source; the swap bit picks the clearing compare.
// - Counter readable as read-only byte pair; A as read/write pair; P one byte.
// - Low three bits of the first control register read as zero.
// - Low bytes go through a shared byte buffer moved by high-byte access.
// - P value compares with counter high byte; A with all sixteen bits.
// - Separate request pulses for comparator A and comparator P matches.
// - Complement output pin is always the inverse of the main output pin.
// ------------------------------------------------------------
package ctm_pkg;

	// ------------------------------------------------------------
	// Register word indexes, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [2:0] IDX_CTRL0 = 3'h0;
	localparam logic [2:0] IDX_CTRL1 = 3'h1;
	localparam logic [2:0] IDX_CNT_LO = 3'h2;
	localparam logic [2:0] IDX_CNT_HI = 3'h3;
	localparam logic [2:0] IDX_CMPA_LO = 3'h4;
	localparam logic [2:0] IDX_CMPA_HI = 3'h5;
	localparam logic [2:0] IDX_CMPP = 3'h6;
	localparam logic [2:0] IDX_LAST = 3'h6;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Clock source codes and prescaler ratios
	// ------------------------------------------------------------
	localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
	localparam logic [2:0] CK_SYS = 3'h1;
	localparam logic [2:0] CK_HI_DIV16 = 3'h2;
	localparam logic [2:0] CK_HI_DIV64 = 3'h3;
	localparam logic [2:0] CK_SUB_A = 3'h4;
	localparam logic [2:0] CK_SUB_B = 3'h5;
	localparam logic [2:0] CK_PIN_RISE = 3'h6;
	localparam logic [2:0] CK_PIN_FALL = 3'h7;
	localparam logic [1:0] SYS_DIV_LAST = 2'h3;
	localparam logic [5:0] HI_DIV16_LAST = 6'h0f;
	localparam logic [5:0] HI_DIV64_LAST = 6'h3f;

	// ------------------------------------------------------------
	// Modes and output functions
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_COMPARE = 2'h0,
		MODE_UNDEF = 2'h1,
		MODE_PWM = 2'h2,
		MODE_TIMER = 2'h3
	} mode_t;
	localparam logic [1:0] IO_HOLD = 2'h0;
	localparam logic [1:0] IO_LOW = 2'h1;
	localparam logic [1:0] IO_HIGH = 2'h2;
	localparam logic [1:0] IO_TOGGLE = 2'h3;
	localparam logic [1:0] IO_PWM_INACTIVE = 2'h0;
	localparam logic [1:0] IO_PWM_ACTIVE = 2'h1;
	localparam logic [1:0] IO_PWM_WAVE = 2'h2;

	// ------------------------------------------------------------
	// Control register layouts
	// ------------------------------------------------------------
	typedef struct packed {
		logic pauseControl;
		logic [2:0] clockSourceSelect;
		logic counterOn;
		logic [2:0] unused;
	} ctrl0_t;
	typedef struct packed {
		mode_t operatingModeSelect;
		logic [1:0] outputFunctionSelect;
		logic outputInitialLevel;
		logic outputPolarityInvert;
		logic dutyPeriodSwap;
		logic clearSourceSelect;
	} ctrl1_t;

endpackage : ctm_pkg

// ### rtl/compact_timer_module.sv
// Module: compact 16-bit timer with AXI4-Lite register access
`timescale 1ns/1ps
module compact_timer_module #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Counting clock sources
	input wire logic highClock,
	input wire logic subClock,
	input wire logic externalClockPin,
	// Timer outputs
	output logic timerOutputPin,
	output logic timerOutputPinInverted,
	// Match requests
	output logic compareAIrq,
	output logic comparePIrq
);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic [3:0] decodeAddr(input logic [ADDR_W-1:0] addr);
		logic hit;
		hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] <= ADDR_W'(ctm_pkg::IDX_LAST));
		return {hit, addr[4:2]};
	endfunction : decodeAddr

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	ctm_pkg::ctrl0_t ctrl0_reg;
	ctm_pkg::ctrl1_t ctrl1_reg;
	logic [15:0] counter_reg;
	logic [15:0] compareA_reg;
	logic [7:0] compareP_reg;
	logic [7:0] lowBuffer_reg;
	logic onPrev_reg;
	logic cmpLevel_reg;
	logic [ADDR_W-1:0] awAddr_reg;
	logic awHeld_reg;
	logic [7:0] wData_reg;
	logic wLane_reg;
	logic wHeld_reg;
	logic sourceTick;

	// ------------------------------------------------------------
	// Clock source
	// ------------------------------------------------------------
	ctm_clock_select clockSelect (
		.ref_clk(ref_clk),
		.rst(rst),
		.highClock(highClock),
		.subClock(subClock),
		.externalClockPin(externalClockPin),
		.clockSourceSelect(ctrl0_reg.clockSourceSelect),
		.sourceTick(sourceTick)
	);

	// ------------------------------------------------------------
	// Write channel handshake
	// ------------------------------------------------------------
	wire awTake = s_axi_awvalid & s_axi_awready;
	wire wTake = s_axi_wvalid & s_axi_wready;
	wire wrFire = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
	wire [3:0] wrDec = decodeAddr(awAddr_reg);
	wire wrHit = wrDec[3];
	wire [2:0] wrIdx = wrDec[2:0];
	wire wrEn = wrFire & wrHit & wLane_reg;
	wire wrCtrl0 = wrEn & (wrIdx == ctm_pkg::IDX_CTRL0);
	wire wrCtrl1 = wrEn & (wrIdx == ctm_pkg::IDX_CTRL1);
	wire wrCmpALo = wrEn & (wrIdx == ctm_pkg::IDX_CMPA_LO);
	wire wrCmpAHi = wrEn & (wrIdx == ctm_pkg::IDX_CMPA_HI);
	wire wrCmpP = wrEn & (wrIdx == ctm_pkg::IDX_CMPP);
	wire awHeld_next = wrFire ? 1'b0 : (awHeld_reg | awTake);
	wire wHeld_next = wrFire ? 1'b0 : (wHeld_reg | wTake);
	wire bvalid_next = wrFire | (s_axi_bvalid & ~s_axi_bready);
	wire [1:0] bresp_next = wrFire ?
		(wrHit ? ctm_pkg::RESP_OKAY : ctm_pkg::RESP_SLVERR) : s_axi_bresp;

	// ------------------------------------------------------------
	// Read channel handshake and data select
	// ------------------------------------------------------------
	wire arTake = s_axi_arvalid & s_axi_arready;
	wire [3:0] rdDec = decodeAddr(s_axi_araddr);
	wire rdHit = rdDec[3];
	wire [2:0] rdIdx = rdDec[2:0];
	wire rdCntHi = arTake & rdHit & (rdIdx == ctm_pkg::IDX_CNT_HI);
	wire rdCmpAHi = arTake & rdHit & (rdIdx == ctm_pkg::IDX_CMPA_HI);
	wire rvalid_next = arTake | (s_axi_rvalid & ~s_axi_rready);
	wire [7:0] ctrl0View = {ctrl0_reg[7:3], 3'h0};
	wire [7:0] rdByte =
		(rdIdx == ctm_pkg::IDX_CTRL0) ? ctrl0View :
		(rdIdx == ctm_pkg::IDX_CTRL1) ? ctrl1_reg :
		(rdIdx == ctm_pkg::IDX_CNT_HI) ? counter_reg[15:8] :
		(rdIdx == ctm_pkg::IDX_CMPA_HI) ? compareA_reg[15:8] :
		(rdIdx == ctm_pkg::IDX_CMPP) ? compareP_reg :
		lowBuffer_reg;
	wire [31:0] rdata_next = arTake ? {24'h000000, rdHit ? rdByte : 8'h00} : s_axi_rdata;
	wire [1:0] rresp_next = arTake ?
		(rdHit ? ctm_pkg::RESP_OKAY : ctm_pkg::RESP_SLVERR) : s_axi_rresp;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	wire counterOn = ctrl0_reg.counterOn;
	wire onRise = counterOn & ~onPrev_reg;
	wire isCompare = ctrl1_reg.operatingModeSelect == ctm_pkg::MODE_COMPARE;
	wire isPwm = ctrl1_reg.operatingModeSelect == ctm_pkg::MODE_PWM;
	wire drivesPin = isCompare | isPwm;
	wire [1:0] ioSel = ctrl1_reg.outputFunctionSelect;
	wire initLevel = ctrl1_reg.outputInitialLevel;

	// ------------------------------------------------------------
	// Counter and comparators
	// ------------------------------------------------------------
	wire tick = sourceTick & counterOn & ~ctrl0_reg.pauseControl;
	wire [15:0] cntInc = counter_reg + 16'h0001;
	wire aZero = compareA_reg == 16'h0000;
	wire pZero = compareP_reg == 8'h00;
	wire aHit = (cntInc == compareA_reg) & ~aZero;
	wire pHit = (cntInc == {compareP_reg, 8'h00}) & ~pZero;
	wire overflow = counter_reg == 16'hffff;
	wire pOverflow = overflow & pZero;
	wire clearByA = isPwm ? ctrl1_reg.dutyPeriodSwap : ctrl1_reg.clearSourceSelect;
	wire aEvent = tick & aHit;
	wire pEvent = tick & (pHit | pOverflow) & (isPwm | ~clearByA);
	wire clearCnt = tick & (clearByA ? aHit : (pHit | overflow));
	wire [15:0] counter_next =
		onRise ? 16'h0000 :
		clearCnt ? 16'h0000 :
		tick ? cntInc :
		counter_reg;

	// ------------------------------------------------------------
	// PWM waveform
	// ------------------------------------------------------------
	wire [16:0] pDuty = pZero ? 17'h10000 : {1'b0, compareP_reg, 8'h00};
	wire [16:0] dutyVal = ctrl1_reg.dutyPeriodSwap ? pDuty : {1'b0, compareA_reg};
	wire pwmActive = {1'b0, counter_reg} < dutyVal;
	wire pwmLevel = pwmActive ? initLevel : ~initLevel;
	wire pwmPin =
		(ioSel == ctm_pkg::IO_PWM_WAVE) ? pwmLevel :
		(ioSel == ctm_pkg::IO_PWM_ACTIVE) ? initLevel :
		~initLevel;

	// ------------------------------------------------------------
	// Compare match output level
	// ------------------------------------------------------------
	wire cmpMatchLevel =
		(ioSel == ctm_pkg::IO_LOW) ? 1'b0 :
		(ioSel == ctm_pkg::IO_HIGH) ? 1'b1 :
		(ioSel == ctm_pkg::IO_TOGGLE) ? ~cmpLevel_reg :
		cmpLevel_reg;
	wire cmpLevel_next =
		(onRise & drivesPin) ? initLevel :
		(aEvent & isCompare) ? cmpMatchLevel :
		cmpLevel_reg;
	wire baseLevel = isPwm ? pwmPin : cmpLevel_reg;
	wire pin_next = drivesPin ? (baseLevel ^ ctrl1_reg.outputPolarityInvert) : 1'b0;

	// ------------------------------------------------------------
	// Bus registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			awAddr_reg <= '0;
			awHeld_reg <= 1'b0;
			wData_reg <= ctm_pkg::RESET_BYTE;
			wLane_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ctm_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= ctm_pkg::RESP_OKAY;
		end else begin
			if (awTake) begin
				awAddr_reg <= s_axi_awaddr;
			end
			if (wTake) begin
				wData_reg <= s_axi_wdata[7:0];
				wLane_reg <= s_axi_wstrb[0];
			end
			awHeld_reg <= awHeld_next;
			wHeld_reg <= wHeld_next;
			s_axi_awready <= ~awHeld_next & ~bvalid_next;
			s_axi_wready <= ~wHeld_next & ~bvalid_next;
			s_axi_bvalid <= bvalid_next;
			s_axi_bresp <= bresp_next;
			s_axi_arready <= ~rvalid_next;
			s_axi_rvalid <= rvalid_next;
			s_axi_rdata <= rdata_next;
			s_axi_rresp <= rresp_next;
		end
	end

	// ------------------------------------------------------------
	// Timer registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl0_reg <= ctm_pkg::RESET_BYTE;
			ctrl1_reg <= ctm_pkg::RESET_BYTE;
			compareA_reg <= 16'h0000;
			compareP_reg <= ctm_pkg::RESET_BYTE;
			lowBuffer_reg <= ctm_pkg::RESET_BYTE;
		end else begin
			if (wrCtrl0) begin
				ctrl0_reg <= {wData_reg[7:3], 3'h0};
			end
			if (wrCtrl1) begin
				ctrl1_reg <= wData_reg;
			end
			if (wrCmpAHi) begin
				compareA_reg <= {wData_reg, lowBuffer_reg};
			end
			if (wrCmpP) begin
				compareP_reg <= wData_reg;
			end
			if (wrCmpALo) begin
				lowBuffer_reg <= wData_reg;
			end else if (rdCntHi) begin
				lowBuffer_reg <= counter_reg[7:0];
			end else if (rdCmpAHi) begin
				lowBuffer_reg <= compareA_reg[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Counter, level and outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			counter_reg <= 16'h0000;
			onPrev_reg <= 1'b0;
			cmpLevel_reg <= 1'b0;
			timerOutputPin <= 1'b0;
			timerOutputPinInverted <= 1'b1;
			compareAIrq <= 1'b0;
			comparePIrq <= 1'b0;
		end else begin
			counter_reg <= counter_next;
			onPrev_reg <= counterOn;
			cmpLevel_reg <= cmpLevel_next;
			timerOutputPin <= pin_next;
			timerOutputPinInverted <= ~pin_next;
			compareAIrq <= aEvent;
			comparePIrq <= pEvent;
		end
	end

endmodule : compact_timer_module

// ### rtl/ctm_clock_select.sv
// Module: counting clock source selection and prescaling
`timescale 1ns/1ps
module ctm_clock_select (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Asynchronous clock sources
	input wire logic highClock,
	input wire logic subClock,
	input wire logic externalClockPin,
	// Selection and tick
	input wire logic [2:0] clockSourceSelect,
	output logic sourceTick
);

	// ------------------------------------------------------------
	// Synchronisers and edge detect
	// ------------------------------------------------------------
	logic [2:0] syncA_reg;
	logic [2:0] syncB_reg;
	logic [2:0] prev_reg;
	logic [1:0] sysDiv_reg;
	logic [5:0] hiDiv_reg;
	wire [2:0] rawIn = {externalClockPin, subClock, highClock};
	wire hiRise = syncB_reg[0] & ~prev_reg[0];
	wire subRise = syncB_reg[1] & ~prev_reg[1];
	wire pinRise = syncB_reg[2] & ~prev_reg[2];
	wire pinFall = ~syncB_reg[2] & prev_reg[2];
	wire div4Tick = sysDiv_reg == ctm_pkg::SYS_DIV_LAST;
	wire div16Tick = hiRise & (hiDiv_reg[3:0] == ctm_pkg::HI_DIV16_LAST[3:0]);
	wire div64Tick = hiRise & (hiDiv_reg == ctm_pkg::HI_DIV64_LAST);

	// ------------------------------------------------------------
	// Source selection
	// ------------------------------------------------------------
	logic tick_next;
	always_comb begin
		case (clockSourceSelect)
			ctm_pkg::CK_SYS_DIV4: tick_next = div4Tick;
			ctm_pkg::CK_SYS: tick_next = 1'b1;
			ctm_pkg::CK_HI_DIV16: tick_next = div16Tick;
			ctm_pkg::CK_HI_DIV64: tick_next = div64Tick;
			ctm_pkg::CK_SUB_A: tick_next = subRise;
			ctm_pkg::CK_SUB_B: tick_next = subRise;
			ctm_pkg::CK_PIN_RISE: tick_next = pinRise;
			ctm_pkg::CK_PIN_FALL: tick_next = pinFall;
			default: tick_next = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			syncA_reg <= 3'h0;
			syncB_reg <= 3'h0;
			prev_reg <= 3'h0;
			sysDiv_reg <= 2'h0;
			hiDiv_reg <= 6'h00;
			sourceTick <= 1'b0;
		end else begin
			syncA_reg <= rawIn;
			syncB_reg <= syncA_reg;
			prev_reg <= syncB_reg;
			sysDiv_reg <= sysDiv_reg + 2'h1;
			hiDiv_reg <= hiRise ? hiDiv_reg + 6'h01 : hiDiv_reg;
			sourceTick <= tick_next;
		end
	end

endmodule : ctm_clock_select

// ### test/compact_timer_module_asserts.sv
// Checker: bus answers, register fields and timer outputs
`timescale 1ns/1ps
module compact_timer_module_asserts #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Bus
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	// Timer
	input wire logic timerOutputPin,
	input wire logic timerOutputPinInverted,
	input wire logic compareAIrq,
	input wire logic comparePIrq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [ADDR_W-1:0] awAddr_reg;
	logic [ADDR_W-1:0] arAddr_reg;
	wire logic awTake = s_axi_awvalid && s_axi_awready;
	wire logic arTake = s_axi_arvalid && s_axi_arready;
	wire logic awBad = awAddr_reg > 8'h18 || awAddr_reg[1:0] != 2'h0;
	wire logic arBad = arAddr_reg > 8'h18 || arAddr_reg[1:0] != 2'h0;
	always_ff @(posedge ref_clk) begin
		if (awTake)
			awAddr_reg <= s_axi_awaddr;
		if (arTake)
			arAddr_reg <= s_axi_araddr;
	end
	a_pin_complement: assert property (timerOutputPinInverted == !timerOutputPin)
		else $error("complement pin differs");
	a_write_answer: assert property (awTake && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	a_read_answer: assert property (arTake |=> s_axi_rvalid)
		else $error("read data missing");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_ctrl0_low: assert property (s_axi_rvalid && arAddr_reg == '0 |-> s_axi_rdata[2:0] == 3'h0)
		else $error("control low bits set");
	a_write_error: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (awBad ? 2'h2 : 2'h0))
		else $error("write response code wrong");
	a_read_error: assert property (s_axi_rvalid && arBad |-> s_axi_rresp == 2'h2 && s_axi_rdata == '0)
		else $error("read response code wrong");
	a_reset_pins: assert property ($fell(rst) |-> !timerOutputPin && !compareAIrq && !comparePIrq)
		else $error("outputs active after reset");
	c_match_a: cover property (compareAIrq);
	c_match_p: cover property (comparePIrq);
	c_bus_error: cover property ($rose(s_axi_bvalid) && awBad);
endmodule : compact_timer_module_asserts

bind compact_timer_module compact_timer_module_asserts #(.ADDR_W(ADDR_W)) chk_i (
	.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .timerOutputPin(timerOutputPin),
	.timerOutputPinInverted(timerOutputPinInverted), .compareAIrq(compareAIrq),
	.comparePIrq(comparePIrq)
);

// ### test/compact_timer_module_bench.sv
// Testbench: register access, counting, compare output and PWM scenarios
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module compact_timer_module_bench;
	// ----
	// Signals
	// ----
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic highClock = 1'b0;
	logic extPin = 1'b0;
	logic [2:0] subDiv = 3'h0;
	logic awready, wready, bvalid, arready, rvalid, pin, pinInv, irqA, irqP;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int miscompares = 0;
	int checks = 0;
	int expTicks[8] = '{256, 1024, 32, 8, 128, 128, 512, 512};
	logic [7:0] pwmCtrl[7] = '{8'ha8, 8'ha9, 8'haa, 8'ha0, 8'hac, 8'h88, 8'h98};
	int pwmHigh[7] = '{256, 256, 1024, 768, 768, 0, 1024};

	compact_timer_module compact_timer_module_i (
		.ref_clk(ref_clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.highClock(highClock), .subClock(subDiv[2]), .externalClockPin(extPin),
		.timerOutputPin(pin), .timerOutputPinInverted(pinInv), .compareAIrq(irqA),
		.comparePIrq(irqP)
	);

	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		highClock <= ~highClock;
		extPin <= ~extPin;
		subDiv <= subDiv + 3'h1;
	end

	// ----
	// Bus tasks
	// ----
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		`CHK("bresp", (a > 8'h18) ? 2'h2 : 2'h0, bresp)
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		d = rdata[7:0];
		`CHK("rresp", (a > 8'h18) ? 2'h2 : 2'h0, rresp)
	endtask : rd
	task automatic rd16(output logic [15:0] v);
		rd(8'h0c, v[15:8]);
		rd(8'h08, v[7:0]);
	endtask : rd16
	task automatic cfg(input logic [7:0] c1, input logic [7:0] c0);
		wr(8'h00, c0 & 8'hf7);
		wr(8'h04, c1);
		wr(8'h00, c0);
	endtask : cfg
	function automatic logic near(input int v, input int e, input int t);
		return v >= e - t && v <= e + t;
	endfunction : near
	task automatic test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	initial begin
		repeat (60000) @(posedge ref_clk);
		miscompares++;
		test_done();
	end

	// ----
	// Scenarios
	// ----
	initial begin
		logic [7:0] d;
		logic [15:0] v, v2;
		logic lvl;
		int cntA, cntP, hi, k;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rd(8'(4 * i), d);
			`CHK("resetValue", 8'h00, d)
		end
		rd(8'h1c, d);
		wr(8'h1c, 8'hff);
		wr(8'h0c, 8'h55);
		rd(8'h0c, d);
		`CHK("counterReadOnly", 8'h00, d)
		wr(8'h00, 8'h87);
		rd(8'h00, d);
		`CHK("ctrl0", 8'h80, d)
		wr(8'h04, 8'ha5);
		rd(8'h04, d);
		`CHK("ctrl1", 8'ha5, d)
		wr(8'h10, 8'h2c);
		wr(8'h14, 8'h01);
		rd(8'h14, d);
		`CHK("compareAHigh", 8'h01, d)
		rd(8'h10, d);
		`CHK("compareALow", 8'h2c, d)
		wr(8'h18, 8'h00);
		for (int i = 0; i < 8; i++) begin
			cfg(8'hc0, {1'b0, 3'(i), 4'h8});
			repeat (1024) @(posedge ref_clk);
			wr(8'h00, {1'b1, 3'(i), 4'h8});
			rd16(v);
			`CHK("ticks", 1'b1, near(int'(v), expTicks[i], expTicks[i] / 16 + 4))
			repeat (40) @(posedge ref_clk);
			rd16(v2);
			`CHK("paused", v, v2)
		end
		cfg(8'hc0, 8'h18);
		repeat (100) @(posedge ref_clk);
		wr(8'h00, 8'h98);
		repeat (100) @(posedge ref_clk);
		wr(8'h00, 8'h18);
		repeat (100) @(posedge ref_clk);
		wr(8'h00, 8'h10);
		rd16(v);
		`CHK("resumed", 1'b1, near(int'(v), 206, 15))
		repeat (40) @(posedge ref_clk);
		rd16(v2);
		`CHK("stopped", v, v2)
		wr(8'h00, 8'h18);
		rd16(v);
		`CHK("restart", 1'b1, near(int'(v), 8, 10))
		wr(8'h18, 8'h01);
		for (int i = 0; i < 16; i++) begin
			cfg({2'b00, 2'(i), i[2], i[3], 2'b01}, 8'h18);
			repeat (10) @(posedge ref_clk);
			`CHK("initialPin", i[2] ^ i[3], pin)
			cntP = 0;
			for (k = 0; k < 400 && !irqA; k++) begin
				@(posedge ref_clk);
				cntP += irqP;
			end
			repeat (2) @(posedge ref_clk);
			lvl = (i[1:0] == 0) ? i[2] : (i[1:0] == 1) ? 1'b0 : (i[1:0] == 2) ? 1'b1 : !i[2];
			`CHK("matchPin", lvl ^ i[3], pin)
			`CHK("pSuppressed", 0, cntP)
		end
		for (int m = 0; m < 2; m++) begin
			cfg(m ? 8'hfd : 8'h30, 8'h18);
			cntA = 0;
			cntP = 0;
			hi = 0;
			repeat (700) begin
				@(posedge ref_clk);
				cntA += irqA;
				cntP += irqP;
				hi += pin;
			end
			`CHK("aEvents", m ? 2 : 0, cntA)
			`CHK("pEvents", m ? 0 : 2, cntP)
			if (m)
				`CHK("timerPin", 0, hi)
		end
		wr(8'h10, 8'h40);
		wr(8'h14, 8'h00);
		for (int i = 0; i < 7; i++) begin
			cfg(pwmCtrl[i], 8'h18);
			repeat (8) @(posedge ref_clk);
			hi = 0;
			cntP = 0;
			repeat (1024) begin
				@(posedge ref_clk);
				hi += pin;
				cntP += irqP;
			end
			`CHK("pwmHigh", 1'b1, near(hi, pwmHigh[i], 4))
			`CHK("pwmP", 1'b1, near(cntP, pwmCtrl[i][1] ? 0 : 4, 1))
		end
		test_done();
	end
endmodule : compact_timer_module_bench
